// *** hw/smc_cfg.svh ***
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// register address and layout
`define SMC_CTRL_ADDR 8'hDF
`define SMC_CTRL_RESET 8'hDE
`define SMC_BIT_DIG_OK 7
`define SMC_BIT_ANA_OK 6
`define SMC_BIT_LOW_FLAG 5
`define SMC_BIT_DIG_SEL_HI 4
`define SMC_BIT_DIG_SEL_LO 3
`define SMC_BIT_ANA_SEL_HI 2
`define SMC_BIT_ANA_SEL_LO 1
`define SMC_BIT_ENABLE 0
`define SMC_WMASK 8'h3F

// timing
`define SMC_CLK_HZ 125000000
`define SMC_RECOVERY_MS 250
`define SMC_RECOVERY_CYCLES ((`SMC_CLK_HZ / 1000) * `SMC_RECOVERY_MS)
`define SMC_GLITCH_NS 1000
`define SMC_GLITCH_CYCLES ((`SMC_GLITCH_NS * 125 + 999) / 1000)

`endif

// *** hw/smc_pkg.sv ***
package smc_pkg;

    // trip point codes, millivolts in the names
    typedef enum logic [1:0] {
        TRIP_4630 = 2'h0,
        TRIP_3080 = 2'h1,
        TRIP_2930 = 2'h2,
        TRIP_2630 = 2'h3
    } smc_trip_t;

    typedef struct packed {
        logic enable;
        smc_trip_t digitalTrip;
        smc_trip_t analogTrip;
    } smc_analog_ctl_t;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smc_sfr_req_t;

    typedef enum logic {
        REC_IDLE,
        REC_COUNT
    } smc_rec_state_t;

endpackage

// *** hw/smc_glitch_filter.sv ***
`timescale 1ns/100ps
`include "smc_cfg.svh"

module smc_glitch_filter #(
    parameter int CYCLES = `SMC_GLITCH_CYCLES,
    parameter int CW = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rawIn,
    input wire logic clearHigh,
    output logic filtOut
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic out;
        logic [CW-1:0] cnt;
    } smc_filt_state_t;

    smc_filt_state_t s_q;
    smc_filt_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.sync1 = rawIn;
        s_d.sync2 = s_q.sync1;
        if (clearHigh) begin
            s_d.out = 1'b1;
            s_d.cnt = '0;
        end else if (s_q.sync2 == s_q.out) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == CW'(CYCLES - 1)) begin
            // only a level held for the whole window is taken
            s_d.out = s_q.sync2;
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{sync1: 1'b1, sync2: 1'b1, out: 1'b1, cnt: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign filtOut = s_q.out;

endmodule // smc_glitch_filter

// *** hw/smc_supply_monitor.sv ***
// Functional notes
// - bit 0 enables the monitor; zero disables it.
// - two-bit digital trip field selects 4.63, 3.08, 2.93 or 2.63 V.
// - two-bit analog trip field uses the same four-way encoding.
// - bit 7 reads the digital comparator, one when above trip.
// - bit 6 reads the analog comparator, one when above trip.
// - flag bit 5 sets whenever either comparator reads low while bit 0 is set and stays set.
// - both comparators high and staying high starts a 250 ms count.
// - count expiry clears the flag automatically.
// - software may write the flag.
// - software clear has no effect while either comparator is low, unless the same write clears bit 0.
// - set flag requests a core interrupt when enabled there.
// - comparator inputs are filtered against brief glitches.
`timescale 1ns/100ps
`include "smc_cfg.svh"

module smc_supply_monitor #(
    parameter int RECOVERY_CYCLES = `SMC_RECOVERY_CYCLES,
    parameter int GLITCH_CYCLES = `SMC_GLITCH_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input smc_pkg::smc_sfr_req_t sfrReq,
    output logic [7:0] sfrRdata,
    input wire logic digitalCmpRaw,
    input wire logic analogCmpRaw,
    output smc_pkg::smc_analog_ctl_t analogCtl,
    input wire logic irqEnable,
    output logic lowSupplyIrq
);

    ////////////////////////////////////////////////////////////////////////
    // filtered comparators

    logic digitalOk;
    logic analogOk;
    logic monitorOn;

    smc_glitch_filter #(.CYCLES(GLITCH_CYCLES), .CW(16)) uDigFilt (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rawIn(digitalCmpRaw),
        .clearHigh(!monitorOn),
        .filtOut(digitalOk)
    );

    smc_glitch_filter #(.CYCLES(GLITCH_CYCLES), .CW(16)) uAnaFilt (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .rawIn(analogCmpRaw),
        .clearHigh(!monitorOn),
        .filtOut(analogOk)
    );

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic enable;
        smc_pkg::smc_trip_t digitalTrip;
        smc_pkg::smc_trip_t analogTrip;
        logic lowFlag;
        smc_pkg::smc_rec_state_t recState;
        logic [31:0] recCnt;
        logic [7:0] rdata;
        logic irq;
    } smc_state_t;

    smc_state_t s_q;
    smc_state_t s_d;

    // reset image of the control byte; enable and trip fields load from it
    localparam logic [7:0] CTRL_RESET = `SMC_CTRL_RESET;

    assign monitorOn = s_q.enable;

    function automatic logic hitCtrl(input smc_pkg::smc_sfr_req_t r, input logic isWrite);
        hitCtrl = (isWrite ? r.wrEn : r.rdEn) && (r.addr == `SMC_CTRL_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    logic suppliesOk;
    logic wrHit;
    logic [7:0] ctrlView;

    always_comb begin
        suppliesOk = digitalOk && analogOk;
        wrHit = hitCtrl(sfrReq, 1'b1);
        ctrlView = {digitalOk, analogOk, s_q.lowFlag, s_q.digitalTrip, s_q.analogTrip,
                    s_q.enable};
        s_d = s_q;

        if (wrHit) begin
            s_d.enable = sfrReq.wdata[`SMC_BIT_ENABLE];
            s_d.digitalTrip = smc_pkg::smc_trip_t'(
                sfrReq.wdata[`SMC_BIT_DIG_SEL_HI:`SMC_BIT_DIG_SEL_LO]);
            s_d.analogTrip = smc_pkg::smc_trip_t'(
                sfrReq.wdata[`SMC_BIT_ANA_SEL_HI:`SMC_BIT_ANA_SEL_LO]);
            if (sfrReq.wdata[`SMC_BIT_LOW_FLAG] || suppliesOk) begin
                s_d.lowFlag = sfrReq.wdata[`SMC_BIT_LOW_FLAG];
            end
        end

        unique case (s_q.recState)
            smc_pkg::REC_IDLE: begin
                if (s_q.lowFlag && suppliesOk) begin
                    s_d.recState = smc_pkg::REC_COUNT;
                    s_d.recCnt = '0;
                end
            end
            smc_pkg::REC_COUNT: begin
                if (!suppliesOk || !s_q.lowFlag) begin
                    // supply dipped again: the full interval restarts later
                    s_d.recState = smc_pkg::REC_IDLE;
                    s_d.recCnt = '0;
                end else if (s_q.recCnt == 32'(RECOVERY_CYCLES - 1)) begin
                    s_d.lowFlag = 1'b0;
                    s_d.recState = smc_pkg::REC_IDLE;
                    s_d.recCnt = '0;
                end else begin
                    s_d.recCnt = s_q.recCnt + 32'h1;
                end
            end
        endcase

        // set on low supply; set wins over software and recovery clears, but disable clears it
        if (s_q.enable && !suppliesOk) begin
            s_d.lowFlag = 1'b1;
        end

        if (!s_d.enable) begin
            s_d.lowFlag = 1'b0;
            s_d.recState = smc_pkg::REC_IDLE;
            s_d.recCnt = '0;
        end

        s_d.rdata = hitCtrl(sfrReq, 1'b0) ? ctrlView : 8'h00;
        s_d.irq = s_d.lowFlag && irqEnable;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.enable <= CTRL_RESET[`SMC_BIT_ENABLE];
            s_q.digitalTrip <= smc_pkg::smc_trip_t'(
                CTRL_RESET[`SMC_BIT_DIG_SEL_HI:`SMC_BIT_DIG_SEL_LO]);
            s_q.analogTrip <= smc_pkg::smc_trip_t'(
                CTRL_RESET[`SMC_BIT_ANA_SEL_HI:`SMC_BIT_ANA_SEL_LO]);
            s_q.lowFlag <= 1'b0;
            s_q.recState <= smc_pkg::REC_IDLE;
            s_q.recCnt <= '0;
            s_q.rdata <= 8'h00;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfrRdata = s_q.rdata;
    assign lowSupplyIrq = s_q.irq;

    always_comb begin
        analogCtl.enable = s_q.enable;
        analogCtl.digitalTrip = s_q.digitalTrip;
        analogCtl.analogTrip = s_q.analogTrip;
    end

endmodule // smc_supply_monitor

// *** tb/smc_supply_sva.sv ***
`timescale 1ns/100ps
`include "smc_cfg.svh"
module smc_supply_sva #(
    parameter int RECOVERY_CYCLES = 50,
    parameter int GLITCH_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input smc_pkg::smc_sfr_req_t sfrReq,
    input logic [7:0] sfrRdata,
    input wire logic digitalCmpRaw,
    input wire logic analogCmpRaw,
    input smc_pkg::smc_analog_ctl_t analogCtl,
    input wire logic irqEnable,
    input logic lowSupplyIrq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic rdHit;
    logic wrHit;
    logic [4:0] ctlRb;
    int hiCnt;
    assign rdHit = sfrReq.rdEn && sfrReq.addr == `SMC_CTRL_ADDR;
    assign wrHit = sfrReq.wrEn && sfrReq.addr == `SMC_CTRL_ADDR;
    assign ctlRb = {analogCtl.digitalTrip, analogCtl.analogTrip, analogCtl.enable};
    // the filtered view lags raw, so this run bounds the recovery from below
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) hiCnt <= 0;
        else hiCnt <= (digitalCmpRaw && analogCmpRaw) ? hiCnt + 1 : 0;
    end
    irq_gate_a: assert property (lowSupplyIrq |-> $past(irqEnable)) else $error("irq gate");
    rd_idle_a: assert property (!$past(rdHit) |-> sfrRdata == 8'h00) else $error("idle rdata");
    rd_ctl_a: assert property (rdHit |=> sfrRdata[4:0] == $past(ctlRb)) else $error("rd ctl");
    wr_ctl_a: assert property (wrHit |=> ctlRb == $past(sfrReq.wdata[4:0])) else $error("wr");
    ctl_hold_a: assert property (!wrHit |=> $stable(analogCtl)) else $error("ctl moved");
    dis_read_a: assert property (!analogCtl.enable [*3] ##0 rdHit |=> sfrRdata[7:5] == 3'h6)
        else $error("disabled status");
    low_sets_a: assert property ((analogCtl.enable && irqEnable && !analogCmpRaw) [*8]
        |-> ##[0:4] lowSupplyIrq) else $error("no low irq");
    held_low_a: assert property ((analogCtl.enable && lowSupplyIrq && !analogCmpRaw) [*8]
        ##0 (irqEnable && !(wrHit && !sfrReq.wdata[0])) |=> lowSupplyIrq)
        else $error("flag lost");
    rec_time_a: assert property ($fell(lowSupplyIrq) && $past(irqEnable) && analogCtl.enable
        && !$past(sfrReq.wrEn) |-> hiCnt >= RECOVERY_CYCLES) else $error("early clear");
endmodule // smc_supply_sva
bind smc_supply_monitor smc_supply_sva #(.RECOVERY_CYCLES(RECOVERY_CYCLES),
    .GLITCH_CYCLES(GLITCH_CYCLES)) u_sva (.core_clk, .rst_n, .sfrReq, .sfrRdata,
    .digitalCmpRaw, .analogCmpRaw, .analogCtl, .irqEnable, .lowSupplyIrq);

// *** tb/smc_cmp_model.sv ***
`timescale 1ns/100ps
module smc_cmp_model (
    input smc_pkg::smc_analog_ctl_t analogCtl,
    input int digMv,
    input int anaMv,
    output logic digitalCmpRaw,
    output logic analogCmpRaw
);
    int tripTab [4] = '{4630, 3080, 2930, 2630};
    assign digitalCmpRaw = digMv > tripTab[analogCtl.digitalTrip];
    assign analogCmpRaw = anaMv > tripTab[analogCtl.analogTrip];
endmodule // smc_cmp_model

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    localparam int REC = 50;
    logic core_clk, rst_n, irqEnable, digitalCmpRaw, analogCmpRaw, lowSupplyIrq;
    logic [7:0] sfrRdata;
    smc_pkg::smc_sfr_req_t sfrReq;
    smc_pkg::smc_analog_ctl_t analogCtl;
    int digMv, anaMv, failures, total_checks, cycles;
    smc_supply_monitor #(.RECOVERY_CYCLES(REC), .GLITCH_CYCLES(4)) u_smc_supply_monitor (
        .core_clk, .rst_n, .sfrReq, .sfrRdata, .digitalCmpRaw, .analogCmpRaw, .analogCtl,
        .irqEnable, .lowSupplyIrq);
    smc_cmp_model u_smc_cmp_model (.analogCtl, .digMv, .anaMv, .digitalCmpRaw, .analogCmpRaw);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic setv(input int d, input int a, input logic ie);
        @(posedge core_clk);
        digMv <= d;
        anaMv <= a;
        irqEnable <= ie;
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge core_clk);
        sfrReq <= '{1'b1, 1'b0, 8'hDF, d};
        @(posedge core_clk);
        sfrReq <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge core_clk);
        sfrReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk);
        sfrReq <= '0;
        #1;
        chk("rdata", sfrRdata & m, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_trip();
        logic [1:0] c;
        setv(3000, 3000, 1'b0);
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr({3'h0, c, c, 1'b1});
            w(12);
            rd(8'hDF, 8'hDF, {c[1], c[1], 1'b0, c, c, 1'b1});
        end
        setv(5000, 5000, 1'b0);
        wr(8'h00);
        $display("trip test done");
    endtask
    task automatic t_low();
        wr(8'h01);
        setv(5000, 2000, 1'b1);
        w(14);
        chk("irq", {7'h00, lowSupplyIrq}, 8'h01);
        rd(8'hDF, 8'hE0, 8'hA0);
        wr(8'h01);
        rd(8'hDF, 8'h20, 8'h20);
        setv(5000, 5000, 1'b1);
        w(REC / 2);
        rd(8'hDF, 8'h20, 8'h20);
        w(REC);
        rd(8'hDF, 8'h20, 8'h00);
        chk("irq", {7'h00, lowSupplyIrq}, 8'h00);
        $display("low supply test done");
    endtask
    task automatic t_misc();
        setv(2000, 5000, 1'b1);
        setv(5000, 5000, 1'b1);
        w(12);
        rd(8'hDF, 8'h20, 8'h00);
        wr(8'h21);
        rd(8'hDF, 8'h20, 8'h20);
        wr(8'h01);
        rd(8'hDF, 8'h20, 8'h00);
        setv(5000, 2000, 1'b1);
        w(14);
        wr(8'h00);
        w(3);
        chk("irq", {7'h00, lowSupplyIrq}, 8'h00);
        rd(8'hDF, 8'hE0, 8'hC0);
        rd(8'h20, 8'hFF, 8'h00);
        setv(5000, 5000, 1'b0);
        $display("glitch soft disable test done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        {rst_n, irqEnable, failures, total_checks, cycles} = '0;
        sfrReq = '0;
        digMv = 5000;
        anaMv = 5000;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'hDF, 8'hFF, 8'hDE);
        t_trip();
        t_low();
        t_misc();
        final_report();
    end
endmodule // testbench
